// file: hw/asrc_ctrl.sv
/*
 Host controller driving an asynchronous 512k x 16 static RAM through its pins.
 Assumes one request at a time on a valid/ready port and a board-level tristate
 resolving data_lines from data_out, data_oe and the memory's own drive.
*/
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - Write happens only while both selects active, strobe low, a lane enabled.
// R2 - Write start is the last of the select, strobe and lane activations.
// R3 - Write end is the first of the select, strobe and lane deactivations.
// R4 - Write window lasts at least 40 ns fast grade, 55 ns slow.
// R5 - Low supply band forces slow-grade timing whatever grade is fitted.
// R6 - Address stable 50 ns fast, 65 ns slow, before write end.
// R7 - Both selects active 50 ns fast, 65 ns slow, before write end.
// R8 - Lane enables valid 50 ns fast, 65 ns slow, before write end.
// R9 - Address valid no later than write start.
// R10 - Address unchanged after the write ends, zero-time hold minimum.
// R11 - Data stable 25 ns fast, 35 ns slow, before end; held after.
// R12 - Memory drives no sooner than 5 ns after a write ends.
// R13 - Memory floats within 20 or 25 ns of strobe activation.
// R14 - Read data valid within 55 ns fast, 70 ns slow, of access start.
// R15 - Read data valid within 30 or 35 ns after output enable.
// R16 - Memory holds old output 10 ns after address change.
// R17 - Memory drive starts no sooner than 10 ns or 5 ns after enables.
// R18 - Memory floats within 20 or 25 ns after disable.
// R19 - Maximum turn-off is shorter than minimum turn-on.
// R20 - Memory drives only selected, reading, enabled lanes.
// R21 - All minimum times are rounded up to whole clock cycles.
module asrc_ctrl
	import asrc_pkg::*;
(
	// Clock and reset.
	input  wire logic                     clk_sys,
	input  wire logic                     srst,
	// Timing grade selects.
	input  wire logic                     fast_grade,
	input  wire logic                     low_supply,
	// Request port.
	input  wire logic                     req_valid,
	input  wire logic                     req_write,
	input  wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	input  wire logic [1:0]               req_lane,
	output logic                          req_ready,
	// Read answer.
	output logic                          rsp_valid,
	output logic [asrc_pkg::DATA_W-1:0]   rsp_rdata,
	// Memory pins.
	output logic [asrc_pkg::ADDR_W-1:0]   addr,
	output logic                          select_active_low,
	output logic                          select_active_high,
	output logic                          write_strobe_n,
	output logic                          output_enable_n,
	output logic                          lower_lane_enable_n,
	output logic                          upper_lane_enable_n,
	input  wire logic [asrc_pkg::DATA_W-1:0] data_lines,
	output logic [asrc_pkg::DATA_W-1:0]   data_out,
	output logic                          data_oe
);
	import asrc_pkg::*;

	asrc_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] data_sync;
	logic use_fast_q;
	logic [1:0] lane_q;

	// Fast limits apply only on the fast grade with normal supply.
	wire use_fast = fast_grade & ~low_supply; // R5
	// Window length covers the longest of pulse width and address, select and lane lead times.
	wire [CNT_W-1:0] win_cyc = use_fast_q ? CNT_W'(WIN_CYC_FAST)
		: CNT_W'(WIN_CYC_SLOW); // R4 R21
	// Read length is loaded at the take, so it follows the grade of this request.
	wire [CNT_W-1:0] read_cyc = use_fast ? CNT_W'(READ_CYC_FAST)
		: CNT_W'(READ_CYC_SLOW);
	wire take = req_valid & req_ready;
	wire cnt_done = (cnt_q == CNT_ONE);
	wire lane_none = (req_lane == 2'h0);

	asrc_sync #(.W(DATA_W)) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.d_in    (data_lines),
		.d_out   (data_sync)
	);

	// Next state and counter.
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
		case (state_q)
			ASRC_IDLE: begin
				if (take && !lane_none) begin
					state_d = req_write ? ASRC_WSET : ASRC_RACC;
					cnt_d = req_write ? CNT_ONE : read_cyc;
				end
			end
			ASRC_WSET: begin
				// One cycle of address and data lead before the strobe.
				state_d = ASRC_WSTB; // R9
				cnt_d = win_cyc;
			end
			ASRC_WSTB: begin
				if (cnt_done) begin
					state_d = ASRC_WHOLD; // R3
					cnt_d = CNT_ONE;
				end
			end
			ASRC_WHOLD: begin
				state_d = ASRC_IDLE; // R10
			end
			ASRC_RACC: begin
				if (cnt_done) begin
					state_d = ASRC_RTURN;
					cnt_d = CNT_W'(TURN_CYC);
				end
			end
			ASRC_RTURN: begin
				if (cnt_done) begin
					state_d = ASRC_IDLE; // R12
				end
			end
			default: begin
				state_d = ASRC_IDLE;
			end
		endcase
	end

	// State, counter and request capture.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ASRC_IDLE;
			cnt_q <= CNT_ZERO;
			use_fast_q <= 1'b0;
			lane_q <= 2'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (take) begin
				use_fast_q <= use_fast; // R5
				lane_q <= req_lane;
			end
		end
	end

	// Pin levels decoded from the next state, so every pin leaves a flip-flop.
	wire nx_active = (state_d != ASRC_IDLE);
	wire nx_strobe = (state_d == ASRC_WSTB); // R1
	wire nx_wdrive = (state_d == ASRC_WSET) || (state_d == ASRC_WSTB)
		|| (state_d == ASRC_WHOLD); // R11
	wire nx_read = (state_d == ASRC_RACC);
	wire [1:0] nx_lane = (state_q == ASRC_IDLE) ? req_lane : lane_q;

	// Pin and answer registers.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			addr <= '0;
			select_active_low <= 1'b1;
			select_active_high <= 1'b0;
			write_strobe_n <= 1'b1;
			output_enable_n <= 1'b1;
			lower_lane_enable_n <= 1'b1;
			upper_lane_enable_n <= 1'b1;
			data_out <= '0;
			data_oe <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			if (take) begin
				addr <= req_addr; // R6
				data_out <= req_wdata;
			end
			// Selects and lanes frame the strobe on both sides.
			select_active_low <= ~nx_active; // R7
			select_active_high <= nx_active; // R7
			lower_lane_enable_n <= ~(nx_active & nx_lane[0]); // R8
			upper_lane_enable_n <= ~(nx_active & nx_lane[1]); // R8
			write_strobe_n <= ~nx_strobe; // R2
			output_enable_n <= ~nx_read;
			data_oe <= nx_wdrive;
			req_ready <= (state_d == ASRC_IDLE) && !take;
			rsp_valid <= (state_q == ASRC_RACC) && cnt_done; // R14
			rsp_rdata <= data_sync;
		end
	end

	// Strobe window length counter for checking.
	logic [CNT_W-1:0] stb_len_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stb_len_q <= CNT_ZERO;
		end else begin
			stb_len_q <= write_strobe_n ? CNT_ZERO : stb_len_q + CNT_ONE;
		end
	end

	localparam int PF = PULSE_CYC_FAST;
	localparam int DF = DATA_CYC_FAST;

	sequence s_strobe_end;
		$rose(write_strobe_n);
	endsequence

	a_strobe_needs_select: assert property (@(posedge clk_sys) disable iff (srst)
		!write_strobe_n |-> !select_active_low && select_active_high) // R1
		else $error("Write strobe active without both selects.");
	a_strobe_needs_lane: assert property (@(posedge clk_sys) disable iff (srst)
		!write_strobe_n |-> !(lower_lane_enable_n && upper_lane_enable_n)) // R1
		else $error("Write strobe active with no lane enabled.");
	a_strobe_starts_last: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(write_strobe_n) |-> $past(!select_active_low) && $past(data_oe)) // R2
		else $error("Strobe did not start after selects and data.");
	a_strobe_ends_first: assert property (@(posedge clk_sys) disable iff (srst)
		s_strobe_end |-> !select_active_low && data_oe) // R3
		else $error("Selects or data dropped before strobe end.");
	a_pulse_width_min: assert property (@(posedge clk_sys) disable iff (srst)
		s_strobe_end |-> stb_len_q >= CNT_W'(PF)) // R4
		else $error("Write window shorter than the fast minimum.");
	a_slow_grade_width: assert property (@(posedge clk_sys) disable iff (srst)
		(s_strobe_end and !use_fast_q) |-> stb_len_q >= CNT_W'(WIN_CYC_SLOW)) // R5
		else $error("Slow timing not applied.");
	a_addr_stable_write: assert property (@(posedge clk_sys) disable iff (srst)
		!write_strobe_n |=> $stable(addr)) // R6
		else $error("Address moved during write.");
	a_data_overlap: assert property (@(posedge clk_sys) disable iff (srst)
		s_strobe_end |-> stb_len_q >= CNT_W'(DF) && $stable(data_out)) // R11
		else $error("Write data overlap too short.");
	a_read_no_drive: assert property (@(posedge clk_sys) disable iff (srst)
		!output_enable_n |-> !data_oe && write_strobe_n) // R12
		else $error("Host drove data during a read.");
endmodule : asrc_ctrl
`default_nettype wire

// file: hw/asrc_pkg.sv
/*
 Constants for the host-side controller of an asynchronous 512k x 16 static RAM.
 Assumes a 250 MHz system clock; all times are converted to whole cycles.
*/
package asrc_pkg;
	// Clock period in picoseconds.
	localparam int CLK_PS = 4000;
	// Address and data widths.
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	// Times in ns, fast grade then slow grade; access and float times are maxima, the rest minima.
	localparam int WRITE_PULSE_NS_FAST = 40;
	localparam int WRITE_PULSE_NS_SLOW = 55;
	localparam int ADDR_TO_WRITE_END_NS_FAST = 50;
	localparam int ADDR_TO_WRITE_END_NS_SLOW = 65;
	localparam int DATA_OVERLAP_MIN_NS_FAST = 25;
	localparam int DATA_OVERLAP_MIN_NS_SLOW = 35;
	localparam int ADDR_ACCESS_MAX_NS_FAST = 55;
	localparam int ADDR_ACCESS_MAX_NS_SLOW = 70;
	localparam int OE_OFF_TO_FLOAT_MAX_NS_SLOW = 25;
	// Minimum times round up to whole cycles.
	function automatic int ns_to_cyc(input int ns);
		return (ns * 1000 + CLK_PS - 1) / CLK_PS;
	endfunction : ns_to_cyc
	// The low window must cover the longest of pulse, address, select and lane times.
	localparam int WIN_CYC_FAST = ns_to_cyc(ADDR_TO_WRITE_END_NS_FAST);
	localparam int WIN_CYC_SLOW = ns_to_cyc(ADDR_TO_WRITE_END_NS_SLOW);
	localparam int PULSE_CYC_FAST = ns_to_cyc(WRITE_PULSE_NS_FAST);
	localparam int PULSE_CYC_SLOW = ns_to_cyc(WRITE_PULSE_NS_SLOW);
	localparam int DATA_CYC_FAST = ns_to_cyc(DATA_OVERLAP_MIN_NS_FAST);
	localparam int DATA_CYC_SLOW = ns_to_cyc(DATA_OVERLAP_MIN_NS_SLOW);
	// Read access, plus two cycles for the input synchroniser.
	localparam int READ_CYC_FAST = ns_to_cyc(ADDR_ACCESS_MAX_NS_FAST) + 2;
	localparam int READ_CYC_SLOW = ns_to_cyc(ADDR_ACCESS_MAX_NS_SLOW) + 2;
	// Idle gap after a read so the memory floats before the next write drives.
	localparam int TURN_CYC = ns_to_cyc(OE_OFF_TO_FLOAT_MAX_NS_SLOW);
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	// Controller states, Gray coded along idle, setup, strobe, hold.
	typedef enum logic [2:0] {
		ASRC_IDLE  = 3'h0,
		ASRC_WSET  = 3'h1,
		ASRC_WSTB  = 3'h3,
		ASRC_WHOLD = 3'h2,
		ASRC_RACC  = 3'h6,
		ASRC_RTURN = 3'h7
	} asrc_state_t;
endpackage : asrc_pkg

// file: hw/asrc_sync.sv
/*
 Two-stage synchroniser for the data lines read back from the memory.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module asrc_sync #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Data.
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] d_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= '0;
			d_out  <= '0;
		end else begin
			meta_q <= d_in;
			d_out  <= meta_q;
		end
	end
endmodule : asrc_sync
`default_nettype wire

// file: tb/asrc_sram_model.sv
/*
 Model of the asynchronous 512k x 16 static RAM behind the controller.
 Assumes a 1 ns unit; the bench resolves the shared data lines.
*/
`timescale 1ns/1ns
`default_nettype none
module asrc_sram_model (
	// Address, control and data pins.
	input  wire logic [18:0] addr,
	input  wire logic        select_active_low,
	input  wire logic        select_active_high,
	input  wire logic        write_strobe_n,
	input  wire logic        output_enable_n,
	input  wire logic        lower_lane_enable_n,
	input  wire logic        upper_lane_enable_n,
	input  wire logic [15:0] data_lines,
	// High applies the slower limits.
	input  wire logic        slow,
	// Drive and host timing faults.
	output logic      [15:0] mem_dq,
	output logic      [1:0]  mem_en,
	output var int           viol
);
	logic    [15:0] mem [0:524287];
	logic    [15:0] q_hold;
	logic    [1:0]  on_l;
	logic           acc_ok;
	realtime        t_beg, t_a, t_s, t_l, t_d, t_acc, t_on, t_off, t_oe;
	wire            sel = !select_active_low && select_active_high;
	wire     [1:0]  lanes = ~{upper_lane_enable_n, lower_lane_enable_n};
	// A write needs all four conditions; a read needs the strobe off and OE on.
	wire            wr = sel && !write_strobe_n && |lanes;
	wire            rd = sel && write_strobe_n && !output_enable_n && |lanes;
	initial viol = 0;
	// Time of the last change on each input group.
	always @(addr) t_a = $realtime;
	always @(select_active_low or select_active_high) t_s = $realtime;
	always @(lanes) t_l = $realtime;
	always @(data_lines) t_d = $realtime;
	always @(addr or rd or lanes) t_acc = $realtime;
	always @(posedge rd) t_on = $realtime;
	always @(negedge output_enable_n) t_oe = $realtime;
	always @(posedge wr) t_beg = $realtime;
	// Lanes store while the window is open, so the last data wins.
	always @* begin
		if (wr && lanes[0]) mem[addr][7:0] = data_lines[7:0];
		if (wr && lanes[1]) mem[addr][15:8] = data_lines[15:8];
	end
	// At the end of the window the host's times are checked.
	// The unknown-to-low step at start-up is not a window and is skipped.
	always @(negedge wr) if (t_beg > 0) begin
		if ($realtime - t_beg < (slow ? 55 : 40)) viol++;
		if ($realtime - (t_a > t_s ? t_a : t_s) < (slow ? 65 : 50)) viol++;
		if ($realtime - t_l < (slow ? 65 : 50)) viol++;
		if ($realtime - t_d < (slow ? 35 : 25)) viol++;
	end
	// Drive runs on odd ns, off the clock edges, and lingers for the turn-off time.
	always begin
		#1;
		if (rd) t_off = $realtime + (slow ? 25 : 20);
		if (rd) on_l = lanes;
		mem_en = (rd ? $realtime - t_on >= 10 : $realtime < t_off) ? on_l : 2'h0;
		acc_ok = ($realtime - t_acc >= (slow ? 70 : 55)) && ($realtime - t_oe >= (slow ? 35 : 30));
		if (acc_ok) q_hold = mem[addr];
		// Old data lingers briefly after an address change, then garbage until access.
		mem_dq = acc_ok ? mem[addr] : ($realtime - t_a < 10) ? q_hold : ~mem[addr];
		#1;
	end
endmodule : asrc_sram_model
`default_nettype wire

// file: tb/test_asrc_ctrl.sv
/*
 Self-checking bench for the static RAM host controller.
 Assumes the memory model beside it; the data lines are resolved here.
*/
`timescale 1ns/1ns
`default_nettype none
module test_asrc_ctrl;
	import asrc_pkg::*;
	logic                   clk_sys = 1'h0, srst = 1'h1, fast_grade = 1'h1, low_supply = 1'h0;
	logic                   req_valid = 1'h0, req_write = 1'h0, req_ready, rsp_valid, data_oe;
	logic                   select_active_low, select_active_high, write_strobe_n;
	logic                   output_enable_n, lower_lane_enable_n, upper_lane_enable_n;
	logic [1:0]             req_lane = 2'h0, mem_en;
	logic [ADDR_W-1:0]      req_addr = 19'h0, addr;
	logic [DATA_W-1:0]      req_wdata = 16'h0, rsp_rdata, data_out, mem_dq, rd, flt_q = 16'h5a5a;
	wire logic [DATA_W-1:0] data_lines;
	int                     n_errors = 0, n_tests = 0, viol, lat, nlow;
	// Host first, then the memory per lane, else a toggling float.
	assign data_lines[7:0] = data_oe ? data_out[7:0] : mem_en[0] ? mem_dq[7:0] : flt_q[7:0];
	assign data_lines[15:8] = data_oe ? data_out[15:8] : mem_en[1] ? mem_dq[15:8] : flt_q[15:8];
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) flt_q <= ~flt_q;
	// Host and memory never drive at once.
	always @(negedge clk_sys) if (!srst) chk(32'(data_oe & |mem_en), 32'h0);
	asrc_ctrl dut (.clk_sys, .srst, .fast_grade, .low_supply, .req_valid, .req_write,
		.req_addr, .req_wdata, .req_lane, .req_ready, .rsp_valid, .rsp_rdata, .addr,
		.select_active_low, .select_active_high, .write_strobe_n, .output_enable_n,
		.lower_lane_enable_n, .upper_lane_enable_n, .data_lines, .data_out, .data_oe);
	asrc_sram_model mdl (.addr, .select_active_low, .select_active_high, .write_strobe_n,
		.output_enable_n, .lower_lane_enable_n, .upper_lane_enable_n, .data_lines,
		.slow(!fast_grade || low_supply), .mem_dq, .mem_en, .viol);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// One request; counts strobe-low cycles and read latency until idle.
	task automatic op(input logic w, input logic [18:0] a, input logic [15:0] d, input logic [1:0] l);
		int i;
		int j;
		{req_valid, req_write, req_addr, req_wdata, req_lane} = {1'h1, w, a, d, l};
		for (i = 0; i < 50 && !req_ready; i++) @(negedge clk_sys);
		@(negedge clk_sys);
		req_valid = 1'h0;
		{lat, nlow, rd} = {32'h0, 32'h0, 16'hxxxx};
		for (j = 0; j < 200 && (j == 0 || !req_ready); j++) begin
			if (rsp_valid === 1'h1) {rd, lat} = {rsp_rdata, j};
			if (write_strobe_n === 1'h0) nlow++;
			@(negedge clk_sys);
		end
		if (i == 50 || j == 200) begin
			n_errors++;
			test_done();
		end
	endtask : op
	// A word written then read back.
	task automatic t_word();
		op(1'h1, 19'h2a5, 16'hc3a5, 2'h3);
		chk(nlow, WIN_CYC_FAST);
		op(1'h0, 19'h2a5, 16'h0, 2'h3);
		chk(32'(rd), 32'hc3a5);
		chk(lat, READ_CYC_FAST);
	endtask : t_word
	// Single-lane writes keep the other byte; a single-lane read returns its byte.
	task automatic t_lanes();
		op(1'h1, 19'h2a5, 16'h993c, 2'h1);
		op(1'h1, 19'h2a5, 16'h7e66, 2'h2);
		op(1'h0, 19'h2a5, 16'h0, 2'h3);
		chk(32'(rd), 32'h7e3c);
		op(1'h0, 19'h2a5, 16'h0, 2'h1);
		chk(32'(rd[7:0]), 32'h3c);
	endtask : t_lanes
	// Low supply on the fast part, then the slow part, both use slow timing.
	task automatic t_slow();
		for (int k = 0; k < 2; k++) begin
			{fast_grade, low_supply} = k ? 2'h0 : 2'h3;
			op(1'h1, 19'h7ffff, 16'h0ff0 ^ 16'(k), 2'h3);
			chk(nlow, WIN_CYC_SLOW);
			op(1'h0, 19'h7ffff, 16'h0, 2'h3);
			chk(32'(rd), 32'(16'h0ff0 ^ 16'(k)));
			chk(lat, READ_CYC_SLOW);
		end
		// A read straight after the grade returns to fast must use fast timing.
		{fast_grade, low_supply} = 2'h2;
		op(1'h0, 19'h7ffff, 16'h0, 2'h3);
		chk(32'(rd), 32'h0ff1);
		chk(lat, READ_CYC_FAST);
	endtask : t_slow
	// A request with no lane is taken but writes nothing.
	task automatic t_drop();
		op(1'h1, 19'h2a5, 16'hffff, 2'h0);
		chk(nlow, 32'h0);
		op(1'h0, 19'h2a5, 16'h0, 2'h3);
		chk(32'(rd), 32'h7e3c);
	endtask : t_drop
	// Reset, then the scenarios, then the verdict.
	initial begin
		repeat (16) @(negedge clk_sys);
		chk({24'h0, select_active_low, select_active_high, write_strobe_n, output_enable_n,
			lower_lane_enable_n, upper_lane_enable_n, data_oe, req_ready}, 32'hbc);
		srst = 1'h0;
		t_word();
		t_lanes();
		t_slow();
		t_drop();
		chk(viol, 32'h0);
		test_done();
	end
endmodule : test_asrc_ctrl
`default_nettype wire
